// >>> rtl/host_power_defs.svh
// Constants for the host power and reset control block
// Operation
// - Backlight PWM repeats at nominal 300 Hz
// - Sense pin pulled down, picks power behaviour
// - Power pin released except momentary command
// - Power pulse level set by power invert
// - Reset pin released, pulsed with reset invert
// - Watchdog resets host through same pin
// - Eight outputs default to front-panel LEDs
`ifndef HOST_POWER_DEFS_SVH
`define HOST_POWER_DEFS_SVH
`define CLK_HZ 50000000
`define PWM_HZ 300
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define PULSE_MS 100
`define PULSE_CYC (`CLK_HZ / 1000 * `PULSE_MS)
`define PWM_W 8
`define CNT_W 24
`define GPO_N 8
`endif

// >>> rtl/host_power_pkg.sv
// Types for the host power and reset control block
`include "host_power_defs.svh"
package host_power_pkg;
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PWR = 3'b010,
        ST_RST = 3'b100
    } seq_state_t;
endpackage : host_power_pkg

// >>> rtl/backlight_pwm.sv
// Backlight pulse-width modulator, 8-bit duty from full off to full on
`timescale 1ns/10ps
`include "host_power_defs.svh"
module backlight_pwm #(
    parameter int PERIOD = `PWM_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Duty
    input wire logic [`PWM_W-1:0] duty_i,
    // Output
    output logic pwm_o
);
    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
        logic out;
    } pwm_state_t;
    pwm_state_t st, next_st;
    logic [`CNT_W+`PWM_W-1:0] thresh;

    always_comb begin
        next_st = st;
        thresh = (`CNT_W+`PWM_W)'(PERIOD) * (`CNT_W+`PWM_W)'(duty_i);
        if (st.cnt >= `CNT_W'(PERIOD - 1)) begin
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + `CNT_W'(1);
        end
        // Compare scaled so duty 255 is fully on
        next_st.out = ((`CNT_W+`PWM_W)'(st.cnt) * (`CNT_W+`PWM_W)'(255)) < thresh;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pwm_o = st.out;

    a_pwm_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
        st.cnt == `CNT_W'(PERIOD - 1) |=> st.cnt == '0)
        else $error("pwm counter did not wrap");
endmodule : backlight_pwm

// >>> rtl/host_power_reset_control.sv
// Host power sense, power and reset pulsing, backlight and LED routing
`timescale 1ns/10ps
`include "host_power_defs.svh"
module host_power_reset_control
#(
    parameter int PULSE_CYC = `PULSE_CYC,
    parameter int PWM_PERIOD = `PWM_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Host power sense pin
    input wire logic pwr_sense_i,
    // Host power switch pin
    input wire logic pwr_ctl_i,
    output logic pwr_ctl_o,
    output logic pwr_ctl_oe_o,
    // Host reset switch pin
    input wire logic rst_ctl_i,
    output logic rst_ctl_o,
    output logic rst_ctl_oe_o,
    // Commands and configuration
    input wire logic pwr_on_req_i,
    input wire logic pwr_off_req_i,
    input wire logic host_reset_req_i,
    input wire logic watchdog_req_i,
    input wire logic pwr_invert_i,
    input wire logic rst_invert_i,
    output logic busy_o,
    output logic host_on_o,
    // Backlight
    input wire logic [`PWM_W-1:0] backlight_duty_i,
    output logic backlight_o,
    // Front-panel outputs
    input wire logic gpo_user_i,
    input wire logic [`GPO_N-1:0] gpo_user_val_i,
    input wire logic [`GPO_N-1:0] led_val_i,
    output logic [`GPO_N-1:0] gpo_o
);
    import host_power_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        seq_state_t state;
        logic [`CNT_W-1:0] cnt;
        logic [1:0] sense_sync;
        logic [1:0] pwr_in_sync;
        logic [1:0] rst_in_sync;
        logic pwr_inv;
        logic rst_inv;
        logic [`GPO_N-1:0] gpo;
    } ctl_state_t;

    ctl_state_t st, next_st;
    logic host_on;
    logic pwr_cmd;
    pin_drive_t pwr_drive;
    pin_drive_t rst_drive;

    // Second stage only, first stage feeds nothing else
    assign host_on = st.sense_sync[1];
    // Power-on only when off, power-off only when on
    assign pwr_cmd = (pwr_on_req_i && !host_on) || (pwr_off_req_i && host_on);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.sense_sync = {st.sense_sync[0], pwr_sense_i};
        next_st.pwr_in_sync = {st.pwr_in_sync[0], pwr_ctl_i};
        next_st.rst_in_sync = {st.rst_in_sync[0], rst_ctl_i};
        // Default routing is the LEDs; user mode hands pins over
        next_st.gpo = gpo_user_i ? gpo_user_val_i : led_val_i;
        case (st.state)
            ST_IDLE: begin
                next_st.cnt = '0;
                // Reset requests win; watchdog shares the reset pin
                if (host_reset_req_i || watchdog_req_i) begin
                    next_st.state = ST_RST;
                    next_st.rst_inv = rst_invert_i;
                end else if (pwr_cmd) begin
                    next_st.state = ST_PWR;
                    next_st.pwr_inv = pwr_invert_i;
                end
            end
            ST_PWR, ST_RST: begin
                if (st.cnt == `CNT_W'(PULSE_CYC - 1)) begin
                    next_st.state = ST_IDLE;
                    next_st.cnt = '0;
                end else begin
                    next_st.cnt = st.cnt + `CNT_W'(1);
                end
            end
            default: begin
                next_st.state = ST_IDLE;
                next_st.cnt = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '{state: ST_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched polarity so a mid-pulse change cannot glitch the pin
    // Each pin's level and enable travel together
    assign pwr_drive = '{o: st.pwr_inv, oe: (st.state == ST_PWR)};
    assign rst_drive = '{o: st.rst_inv, oe: (st.state == ST_RST)};
    assign pwr_ctl_oe_o = pwr_drive.oe;
    assign pwr_ctl_o = pwr_drive.o;
    assign rst_ctl_oe_o = rst_drive.oe;
    assign rst_ctl_o = rst_drive.o;
    assign busy_o = (st.state != ST_IDLE);
    assign host_on_o = host_on;
    assign gpo_o = st.gpo;

    ////////////////////////////////////////////////////////////////////////
    backlight_pwm #(
        .PERIOD(PWM_PERIOD)
    ) u_pwm (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .duty_i(backlight_duty_i),
        .pwm_o(backlight_o)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence s_reset_start;
        !srst_i && st.state == ST_IDLE && (host_reset_req_i || watchdog_req_i);
    endsequence

    sequence s_pwr_start;
        st.state == ST_IDLE && !host_reset_req_i && !watchdog_req_i && pwr_cmd;
    endsequence

    sequence s_rst_last;
        st.state == ST_RST && st.cnt == `CNT_W'(PULSE_CYC - 1);
    endsequence

    sequence s_pulse_mid;
        busy_o && st.cnt != `CNT_W'(PULSE_CYC - 1);
    endsequence

    // Two clean edges fill both synchroniser stages with pin data; the third samples them
    sequence s_sync_settled;
        !srst_i && !$past(srst_i) && !$past(srst_i, 2);
    endsequence

    a_reset_pulse_starts: assert property (@(posedge clk_i) disable iff (srst_i)
        s_reset_start |=> rst_ctl_oe_o && rst_ctl_o == $past(rst_invert_i))
        else $error("reset pulse did not start");
    a_watchdog_reset: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_IDLE && watchdog_req_i |=> rst_ctl_oe_o)
        else $error("watchdog did not drive reset pin");
    a_power_start: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_IDLE && !host_reset_req_i && !watchdog_req_i && pwr_cmd
        |=> pwr_ctl_oe_o && pwr_ctl_o == $past(pwr_invert_i))
        else $error("power pulse did not start");
    a_power_polarity_held: assert property (@(posedge clk_i) disable iff (srst_i)
        pwr_ctl_oe_o && $past(pwr_ctl_oe_o) |-> $stable(pwr_ctl_o))
        else $error("power polarity changed mid pulse");
    a_power_released: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_PWR && st.cnt == `CNT_W'(PULSE_CYC - 1) |=> !pwr_ctl_oe_o)
        else $error("power pin not released");
    a_no_double_drive: assert property (@(posedge clk_i) disable iff (srst_i)
        !(pwr_ctl_oe_o && rst_ctl_oe_o))
        else $error("both control pins driven");
    a_sense_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_IDLE && !host_reset_req_i && !watchdog_req_i
        && pwr_on_req_i && !pwr_off_req_i && host_on |=> !pwr_ctl_oe_o)
        else $error("power-on issued while host on");
    a_led_default: assert property (@(posedge clk_i) disable iff (srst_i)
        !srst_i && !gpo_user_i |=> gpo_o == $past(led_val_i))
        else $error("outputs not routed to leds");
    a_pulse_count: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state != ST_IDLE |-> st.cnt < `CNT_W'(PULSE_CYC))
        else $error("pulse counter overran");
    a_power_busy_set: assert property (@(posedge clk_i) disable iff (srst_i)
        s_pwr_start |=> busy_o && !rst_ctl_oe_o)
        else $error("power pulse did not raise busy");
    a_reset_released: assert property (@(posedge clk_i) disable iff (srst_i)
        s_rst_last |=> !rst_ctl_oe_o && !busy_o)
        else $error("reset pin not released");
    a_reset_polarity_held: assert property (@(posedge clk_i) disable iff (srst_i)
        rst_ctl_oe_o && $past(rst_ctl_oe_o) |-> $stable(rst_ctl_o))
        else $error("reset polarity changed mid pulse");
    a_reset_wins: assert property (@(posedge clk_i) disable iff (srst_i)
        s_reset_start |=> !pwr_ctl_oe_o)
        else $error("power pin driven with reset pending");
    a_idle_released: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_IDLE |-> !pwr_ctl_oe_o && !rst_ctl_oe_o)
        else $error("pin driven while idle");
    a_busy_matches: assert property (@(posedge clk_i) disable iff (srst_i)
        busy_o == (pwr_ctl_oe_o || rst_ctl_oe_o))
        else $error("busy does not match pin drive");
    a_pulse_from_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(busy_o) |-> st.cnt == '0)
        else $error("pulse started with stale count");
    a_busy_refused: assert property (@(posedge clk_i) disable iff (srst_i)
        s_pulse_mid |=> st.state == $past(st.state))
        else $error("request taken while busy");
    a_off_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        st.state == ST_IDLE && !host_reset_req_i && !watchdog_req_i
        && pwr_off_req_i && !pwr_on_req_i && !host_on |=> !pwr_ctl_oe_o)
        else $error("power-off issued while host off");
    a_user_route: assert property (@(posedge clk_i) disable iff (srst_i)
        !srst_i && gpo_user_i |=> gpo_o == $past(gpo_user_val_i))
        else $error("outputs not handed to user");

    ////////////////////////////////////////////////////////////////////////
    // Pin readback is synchronised even though no logic acts on it yet
    a_sense_sync: assert property (@(posedge clk_i) disable iff (srst_i)
        s_sync_settled |-> host_on == $past(pwr_sense_i, 2))
        else $error("sense synchroniser out of step");
    a_pwr_pin_sync: assert property (@(posedge clk_i) disable iff (srst_i)
        s_sync_settled |-> st.pwr_in_sync[1] == $past(pwr_ctl_i, 2))
        else $error("power pin synchroniser out of step");
    a_rst_pin_sync: assert property (@(posedge clk_i) disable iff (srst_i)
        s_sync_settled |-> st.rst_in_sync[1] == $past(rst_ctl_i, 2))
        else $error("reset pin synchroniser out of step");
endmodule : host_power_reset_control

// >>> dv/host_board_model.sv
// Host board model: switch inputs with pull-ups and the switched supply
`timescale 1ns/10ps
module host_board_model (
    // Block pin drives
    input wire logic pwr_drv_i,
    input wire logic pwr_drv_oe_i,
    input wire logic rst_drv_i,
    input wire logic rst_drv_oe_i,
    // Host state
    input wire logic host_on_i,
    // Wire levels
    output logic pwr_pin_o,
    output logic rst_pin_o,
    output logic pwr_sense_o
);
    // Board pull-ups hold released pins high; pins stay in default mode
    assign pwr_pin_o = pwr_drv_oe_i ? pwr_drv_i : 1'b1;
    assign rst_pin_o = rst_drv_oe_i ? rst_drv_i : 1'b1;
    assign pwr_sense_o = host_on_i;
endmodule : host_board_model

// >>> dv/tb_top.sv
// Self-checking bench for the host power and reset control block
`timescale 1ns/10ps
module tb_top;
    import host_power_pkg::*;
    localparam int PULSE = 8;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic host_on = 1'b0, pwr_on_req = 1'b0, pwr_off_req = 1'b0;
    logic reset_req = 1'b0, wd_req = 1'b0, pwr_inv = 1'b0, rst_inv = 1'b0;
    logic gpo_user = 1'b0;
    logic [7:0] duty = 8'h80, user_val = 8'h5a, led_val = 8'ha5, gpo;
    logic pwr_o, pwr_oe, rst_o, rst_oe, busy, host_on_s, backlight;
    logic pwr_pin, rst_pin, sense;
    int err_count = 0;
    int n_checks = 0;
    always #10 clk_i = ~clk_i;
    host_board_model board (.pwr_drv_i(pwr_o), .pwr_drv_oe_i(pwr_oe), .rst_drv_i(rst_o),
        .rst_drv_oe_i(rst_oe), .host_on_i(host_on), .pwr_pin_o(pwr_pin),
        .rst_pin_o(rst_pin), .pwr_sense_o(sense));
    host_power_reset_control #(.PULSE_CYC(PULSE), .PWM_PERIOD(20)) DUT (.clk_i(clk_i),
        .srst_i(srst_i), .pwr_sense_i(sense), .pwr_ctl_i(pwr_pin), .pwr_ctl_o(pwr_o),
        .pwr_ctl_oe_o(pwr_oe), .rst_ctl_i(rst_pin), .rst_ctl_o(rst_o),
        .rst_ctl_oe_o(rst_oe), .pwr_on_req_i(pwr_on_req), .pwr_off_req_i(pwr_off_req),
        .host_reset_req_i(reset_req), .watchdog_req_i(wd_req), .pwr_invert_i(pwr_inv),
        .rst_invert_i(rst_inv), .busy_o(busy), .host_on_o(host_on_s),
        .backlight_duty_i(duty), .backlight_o(backlight), .gpo_user_i(gpo_user),
        .gpo_user_val_i(user_val), .led_val_i(led_val), .gpo_o(gpo));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // Request was raised last edge; this edge takes it, then the drive is timed
    task automatic pulse(input logic sel_rst, input int exp_len, input logic exp_lvl);
        int n;
        n = 0;
        @(posedge clk_i);
        {pwr_on_req, pwr_off_req, reset_req, wd_req} <= 4'h0;
        #1;
        while ((sel_rst ? rst_oe : pwr_oe) === 1'b1 && n < 50) begin
            check((sel_rst ? rst_pin : pwr_pin) === exp_lvl, "drive level");
            n++;
            @(posedge clk_i);
            #1;
        end
        check(n == exp_len, "pulse length");
        check(busy === 1'b0, "busy after pulse");
        @(posedge clk_i);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reset_pulses;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            rst_inv <= i[0];
            reset_req <= ~i[1];
            wd_req <= i[1];
            pulse(1'b1, PULSE, i[0]);
        end
    endtask : reset_pulses
    // Power pulse only when the request suits the sensed host state
    task automatic power_pulses;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            host_on <= i[1];
            repeat (4) @(posedge clk_i);
            check(host_on_s === i[1], "sense");
            pwr_inv <= i[0];
            pwr_on_req <= 1'b1;
            pulse(1'b0, i[1] ? 0 : PULSE, i[0]);
            pwr_off_req <= 1'b1;
            pulse(1'b0, i[1] ? PULSE : 0, i[0]);
        end
    endtask : power_pulses
    task automatic pwm_rate;
        time t0;
        @(posedge backlight);
        t0 = $time;
        @(posedge backlight);
        check(($time - t0) == 400, "pwm period");
    endtask : pwm_rate
    task automatic gpo_route;
        repeat (3) @(posedge clk_i);
        #1;
        check(gpo === led_val, "led routing");
        @(posedge clk_i);
        gpo_user <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        check(gpo === user_val, "user routing");
    endtask : gpo_route
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (7) @(posedge clk_i);
        #1;
        check(pwr_oe === 1'b0 && rst_oe === 1'b0 && gpo === 8'h00, "reset state");
        @(posedge clk_i);
        srst_i <= 1'b0;
        reset_pulses();
        power_pulses();
        pwm_rate();
        gpo_route();
        complete_run();
    end
    initial begin
        #200000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : tb_top
